/* File: dv/dual_port_onchip_ram_tb.sv */
// Self-checking bench for the dual-port on-chip RAM
`timescale 1ns/100ps
`default_nettype none
module dual_port_onchip_ram_tb;
    import uram_pkg::*;
    logic CORE_CLK_I; // Clock
    logic SRST_I; // Reset
    logic sleep; // Sleep level
    logic lb_req, lb_we, lb_ack, lb_err; // Local port
    logic sc_req, sc_we, sc_ack, sc_err; // System CPU/DSP port
    logic sd_req, sd_we, sd_ack, sd_err; // DMA port
    uram_size_t lb_size, sc_size, sd_size; // Sizes
    uram_addr_t lb_addr, sc_addr, sd_addr; // Addresses
    uram_word_t lb_wd, sc_wd, sd_wd, lb_rd, sb_rd; // Data
    int num_errors = 0; // Mismatch count
    int comparisons = 0; // Compare count
    // Device under test
    uram_top i_dut (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .SLEEP_I(sleep),
        .LB_REQ_I(lb_req), .LB_WE_I(lb_we), .LB_SIZE_I(lb_size), .LB_ADDR_I(lb_addr),
        .LB_WDATA_I(lb_wd), .LB_ACK_O(lb_ack), .LB_ERR_O(lb_err), .LB_RDATA_O(lb_rd),
        .SC_REQ_I(sc_req), .SC_WE_I(sc_we), .SC_SIZE_I(sc_size), .SC_ADDR_I(sc_addr),
        .SC_WDATA_I(sc_wd), .SC_ACK_O(sc_ack), .SC_ERR_O(sc_err),
        .SD_REQ_I(sd_req), .SD_WE_I(sd_we), .SD_SIZE_I(sd_size), .SD_ADDR_I(sd_addr),
        .SD_WDATA_I(sd_wd), .SD_ACK_O(sd_ack), .SD_ERR_O(sd_err), .SB_RDATA_O(sb_rd));
    // Three masters on the three request ports
    uram_master i_lb (.clk_i(CORE_CLK_I), .ack_i(lb_ack), .err_i(lb_err), .req_o(lb_req),
        .we_o(lb_we), .size_o(lb_size), .addr_o(lb_addr), .wdata_o(lb_wd));
    uram_master i_sc (.clk_i(CORE_CLK_I), .ack_i(sc_ack), .err_i(sc_err), .req_o(sc_req),
        .we_o(sc_we), .size_o(sc_size), .addr_o(sc_addr), .wdata_o(sc_wd));
    uram_master i_sd (.clk_i(CORE_CLK_I), .ack_i(sd_ack), .err_i(sd_err), .req_o(sd_req),
        .we_o(sd_we), .size_o(sd_size), .addr_o(sd_addr), .wdata_o(sd_wd));
    // 100 MHz clock
    initial CORE_CLK_I = 1'b0;
    always #5 CORE_CLK_I = ~CORE_CLK_I;
    // Verdict and end of run
    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One compare with report
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // Port select: 0 local, 1 system CPU/DSP, 2 DMA
    task automatic go(int p, logic w, uram_size_t s, uram_addr_t a, uram_word_t d,
        output int lat, output logic e);
        case (p)
            0: i_lb.access(w, s, a, d, lat, e);
            1: i_sc.access(w, s, a, d, lat, e);
            default: i_sd.access(w, s, a, d, lat, e);
        endcase
    endtask
    // Transfer with latency, error and read data judged
    task automatic xfer(int p, logic w, uram_size_t s, uram_addr_t a, uram_word_t d,
        int elat, logic eerr);
        int lat;
        logic e;
        go(p, w, s, a, d, lat, e);
        if (lat >= 50) begin
            num_errors++;
            complete_run();
        end
        chk("latency", elat, lat);
        chk("error", eerr, e);
        if (!w && !eerr) begin
            chk("rdata", d, (p == 0) ? lb_rd : sb_rd);
        end
    endtask
    // Both windows, both ends, all ports, and misses
    task automatic t_windows();
        uram_addr_t b;
        uram_addr_t l;
        for (int p = 0; p < 3; p++) begin
            b = ((p == 0) ? UNC_BASE : CACHE_BASE) + 32'(4 * p);
            l = ((p == 0) ? UNC_LAST : CACHE_LAST) - 32'(3 + 4 * p);
            xfer(p, 1'b1, URAM_SZ_W, b, 32'hA0000000 | 32'(p), (p == 0) ? 1 : 2, 1'b0);
            xfer(p, 1'b1, URAM_SZ_W, l, 32'hB0000000 | 32'(p), (p == 0) ? 1 : 2, 1'b0);
            xfer(p, 1'b0, URAM_SZ_W, b, 32'hA0000000 | 32'(p), (p == 0) ? 1 : 2, 1'b0);
            xfer(p, 1'b0, URAM_SZ_W, l, 32'hB0000000 | 32'(p), (p == 0) ? 1 : 2, 1'b0);
        end
        xfer(2, 1'b0, URAM_SZ_W, CACHE_BASE, 32'hA0000000, 2, 1'b0);
        xfer(0, 1'b0, URAM_SZ_W, UNC_LAST - 32'h7, 32'hB0000001, 1, 1'b0);
        xfer(0, 1'b1, URAM_SZ_W, CACHE_BASE, 32'h0, 1, 1'b1);
        xfer(1, 1'b1, URAM_SZ_W, UNC_BASE, 32'h0, 1, 1'b1);
        xfer(2, 1'b0, URAM_SZ_W, CACHE_LAST + 32'h1, 32'h0, 1, 1'b1);
        xfer(0, 1'b0, URAM_SZ_W, UNC_BASE - 32'h4, 32'h0, 1, 1'b1);
    endtask
    // Byte lanes and halfwords merged into one word
    task automatic t_sizes();
        for (int k = 0; k < 4; k++) begin
            xfer(0, 1'b1, URAM_SZ_B, UNC_BASE + 32'(32'h20 + k), 32'(32'h10 + k), 1, 1'b0);
        end
        xfer(0, 1'b0, URAM_SZ_W, UNC_BASE + 32'h20, 32'h13121110, 1, 1'b0);
        xfer(1, 1'b1, URAM_SZ_H, CACHE_BASE + 32'h22, 32'h0000BEEF, 2, 1'b0);
        xfer(2, 1'b1, URAM_SZ_H, CACHE_BASE + 32'h20, 32'h00005A5A, 2, 1'b0);
        xfer(0, 1'b0, URAM_SZ_H, UNC_BASE + 32'h20, 32'hBEEF5A5A, 1, 1'b0);
        xfer(1, 1'b0, URAM_SZ_W, CACHE_BASE + 32'h20, 32'hBEEF5A5A, 2, 1'b0);
    endtask
    // Local access one cycle after a system access, same or other page
    task automatic t_page(logic same);
        uram_addr_t o;
        o = same ? 32'h60 : 32'h10060;
        xfer(0, 1'b1, URAM_SZ_W, UNC_BASE + o, 32'h0BAD0BAD, 1, 1'b0);
        fork
            xfer(1, 1'b1, URAM_SZ_W, CACHE_BASE + 32'h60, 32'h5EC0DA7A, 2, 1'b0);
            begin
                @(negedge CORE_CLK_I);
                xfer(0, 1'b0, URAM_SZ_W, UNC_BASE + o, same ? 32'h5EC0DA7A : 32'h0BAD0BAD,
                    same ? 2 : 1, 1'b0);
            end
        join
    endtask
    // CPU and DMA contend for the system port
    task automatic t_arb();
        int l1, l2;
        logic e1, e2;
        fork
            i_sc.access(1'b1, URAM_SZ_W, CACHE_BASE + 32'h40, 32'hC0DE0001, l1, e1);
            i_sd.access(1'b1, URAM_SZ_W, CACHE_BASE + 32'h40, 32'hD0DE0002, l2, e2);
        join
        chk("first grant", 2, (l1 < l2) ? l1 : l2);
        // Last system grant before this went to the CPU, so the DMA holds the turn
        chk("turn holder", 2, l2);
        // Loser is taken in the idle cycle in which the winner's ack is up
        chk("loser wait", 4, l1);
        chk("second grant", 1, (l1 != l2) && (l1 + l2 <= 8));
        chk("grant error", 0, e1 | e2);
        xfer(0, 1'b0, URAM_SZ_W, UNC_BASE + 32'h40, (l1 > l2) ? 32'hC0DE0001 : 32'hD0DE0002,
            1, 1'b0);
    endtask
    // Sleep refuses system masters, local port keeps working
    task automatic t_sleep();
        xfer(0, 1'b1, URAM_SZ_W, UNC_BASE + 32'h50, 32'h600DF00D, 1, 1'b0);
        @(negedge CORE_CLK_I);
        sleep = 1'b1;
        xfer(1, 1'b1, URAM_SZ_W, CACHE_BASE + 32'h50, 32'h1, 1, 1'b1);
        xfer(2, 1'b1, URAM_SZ_W, CACHE_BASE + 32'h50, 32'h2, 1, 1'b1);
        xfer(0, 1'b0, URAM_SZ_W, UNC_BASE + 32'h50, 32'h600DF00D, 1, 1'b0);
        @(negedge CORE_CLK_I);
        sleep = 1'b0;
        xfer(2, 1'b0, URAM_SZ_W, CACHE_BASE + 32'h50, 32'h600DF00D, 2, 1'b0);
    endtask
    // Reset, scenarios, verdict
    initial begin
        SRST_I = 1'b1;
        sleep = 1'b0;
        repeat (4) @(posedge CORE_CLK_I);
        @(negedge CORE_CLK_I);
        SRST_I = 1'b0;
        t_windows();
        t_sizes();
        t_page(1'b1);
        t_page(1'b0);
        t_arb();
        t_sleep();
        complete_run();
    end
endmodule
`default_nettype wire

/* File: dv/uram_master.sv */
// Behavioural bus master standing in for a CPU, DSP or DMA requester
`timescale 1ns/100ps
`default_nettype none
module uram_master (
    input wire logic clk_i, // System clock
    input wire logic ack_i, // Done pulse from the RAM
    input wire logic err_i, // Refusal pulse from the RAM
    output logic req_o, // Request level
    output logic we_o, // Write when high
    output uram_pkg::uram_size_t size_o, // Access size
    output uram_pkg::uram_addr_t addr_o, // Byte address
    output uram_pkg::uram_word_t wdata_o // Write data
);
    import uram_pkg::*;
    // Quiet bus at time zero
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        size_o = URAM_SZ_W;
        addr_o = '0;
        wdata_o = '0;
    end
    // One transfer held until ack; the caller picks the window
    // Callers give aligned writes only and may contend on purpose
    task automatic access(input logic w, input uram_size_t s, input uram_addr_t a,
        input uram_word_t d, output int lat, output logic e);
        lat = 0;
        @(negedge clk_i);
        req_o = 1'b1;
        we_o = w;
        size_o = s;
        addr_o = a;
        wdata_o = d;
        // Bounded wait for the answer
        do begin
            @(negedge clk_i);
            lat++;
        end while (ack_i !== 1'b1 && lat < 50);
        e = err_i;
        // Release with inverted leftovers so stale values never pass
        req_o = 1'b0;
        we_o = ~w;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

/* File: include/uram_acc_if.sv */
// Access channel between the port logic and one page of storage
`timescale 1ns/100ps
`default_nettype none
interface uram_acc_if;
    import uram_pkg::*;
    logic en; // Access this cycle
    logic we; // Write when high
    logic [3:0] be; // Byte enables
    uram_idx_t idx; // Word index in page
    uram_word_t wdata; // Lane-steered write data
    uram_word_t rdata; // Word at idx
    modport ctl (output en, we, be, idx, wdata, input rdata);
    modport mem (input en, we, be, idx, wdata, output rdata);
endinterface
`default_nettype wire

/* File: include/uram_pkg.sv */
// Constants, types and decode functions shared by the on-chip RAM block
// Notes on behaviour
// - Decode 128 kbytes in both address windows
// - Two independent read/write ports: local, system
// - CPU accesses of 8, 16, 32 bits
// - DSP accesses of 16 or 32 bits
// - Address bit splits storage into two pages
// - System port wins same-location collisions
// - Different pages served in parallel, no delay
// - Cacheable window on system, uncached on local
// - Local access one cycle, system takes longer
// - DSP uses same window-to-port mapping
// - CPU and DMA contend; device arbitrates system bus
// - DMA reaches memory only via system port
// - Sleep refuses all system bus masters
`default_nettype none
package uram_pkg;
    // Requester slots
    localparam int NREQ = 3;
    localparam int REQ_LB = 0;
    localparam int REQ_SC = 1;
    localparam int REQ_SD = 2;

    // Address, data and index types
    typedef logic [31:0] uram_addr_t;
    typedef logic [31:0] uram_word_t;
    typedef logic [13:0] uram_idx_t;

    // Access size codes
    typedef enum logic [1:0] {
        URAM_SZ_B = 2'h0,
        URAM_SZ_H = 2'h1,
        URAM_SZ_W = 2'h2
    } uram_size_t;

    // System port states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_ACC = 2'h2
    } uram_sst_t;

    // Address windows
    localparam uram_addr_t CACHE_BASE = 32'h055F0000;
    localparam uram_addr_t CACHE_LAST = 32'h0560FFFF;
    localparam uram_addr_t UNC_BASE = 32'hA55F0000;
    localparam uram_addr_t UNC_LAST = 32'hA560FFFF;

    // Page split and page depth
    localparam int PAGE_BIT = 16;
    localparam int PAGE_WORDS = 16384;

    // Values after reset
    localparam logic RR_INIT = 1'b0;
    localparam uram_word_t RDATA_INIT = 32'h00000000;

    // Window hit test
    function automatic logic uram_in_win(uram_addr_t a, uram_addr_t base, uram_addr_t last);
        return (a >= base) && (a <= last);
    endfunction

    // Offset into the array
    function automatic uram_addr_t uram_off(uram_addr_t a, uram_addr_t base);
        return a - base;
    endfunction

    // Byte enables from size and low address bits
    function automatic logic [3:0] uram_be(uram_size_t sz, logic [1:0] lo);
        logic [3:0] be;
        be = 4'hF;
        case (sz)
            URAM_SZ_B: begin
                case (lo)
                    2'h0: be = 4'h1;
                    2'h1: be = 4'h2;
                    2'h2: be = 4'h4;
                    default: be = 4'h8;
                endcase
            end
            URAM_SZ_H: be = lo[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
        return be;
    endfunction
endpackage
`default_nettype wire

/* File: verilog/uram_bank.sv */
// One page of storage with a single access channel
`timescale 1ns/100ps
`default_nettype none
module uram_bank (
    input wire logic clk_i,
    uram_acc_if.mem acc
);
    import uram_pkg::*;

    uram_word_t mem_ff [PAGE_WORDS]; // Page contents, no reset

    // Byte-masked write; misaligned writes are not screened
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < 4; b++) begin
            if (acc.en && acc.we && acc.be[b]) begin
                mem_ff[acc.idx][8*b +: 8] <= acc.wdata[8*b +: 8];
            end
        end
    end

    // Read is combinational; the caller registers it
    assign acc.rdata = mem_ff[acc.idx];
endmodule
`default_nettype wire

/* File: verilog/uram_lane.sv */
// Byte-lane steering for one requester
`timescale 1ns/100ps
`default_nettype none
module uram_lane (
    input wire uram_pkg::uram_size_t size_i,
    input wire logic [1:0] addr_lo_i,
    input wire uram_pkg::uram_word_t wdata_i,
    output logic [3:0] be_o,
    output uram_pkg::uram_word_t wdata_o
);
    import uram_pkg::*;

    // Enables by size and address, data replicated onto every lane
    always_comb begin
        be_o = uram_be(size_i, addr_lo_i);
        case (size_i)
            URAM_SZ_B: wdata_o = {4{wdata_i[7:0]}};
            URAM_SZ_H: wdata_o = {2{wdata_i[15:0]}};
            default: wdata_o = wdata_i;
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/uram_top.sv */
// Dual-port on-chip RAM: local bus port and shared system bus port
`timescale 1ns/100ps
`default_nettype none
module uram_top (
    input wire logic CORE_CLK_I, // System clock
    input wire logic SRST_I, // Synchronous reset
    input wire logic SLEEP_I, // Sleep mode level
    input wire logic LB_REQ_I, // Local request, held to ack
    input wire logic LB_WE_I, // Local write
    input wire uram_pkg::uram_size_t LB_SIZE_I, // Local size
    input wire uram_pkg::uram_addr_t LB_ADDR_I, // Local address
    input wire uram_pkg::uram_word_t LB_WDATA_I, // Local write data
    output logic LB_ACK_O, // Local done pulse
    output logic LB_ERR_O, // Local decode miss
    output uram_pkg::uram_word_t LB_RDATA_O, // Local read word
    input wire logic SC_REQ_I, // System CPU/DSP request
    input wire logic SC_WE_I, // System CPU/DSP write
    input wire uram_pkg::uram_size_t SC_SIZE_I, // System CPU/DSP size
    input wire uram_pkg::uram_addr_t SC_ADDR_I, // System CPU/DSP address
    input wire uram_pkg::uram_word_t SC_WDATA_I, // System CPU/DSP data
    output logic SC_ACK_O, // System CPU/DSP done pulse
    output logic SC_ERR_O, // System CPU/DSP refused
    input wire logic SD_REQ_I, // DMA request
    input wire logic SD_WE_I, // DMA write
    input wire uram_pkg::uram_size_t SD_SIZE_I, // DMA size
    input wire uram_pkg::uram_addr_t SD_ADDR_I, // DMA address
    input wire uram_pkg::uram_word_t SD_WDATA_I, // DMA write data
    output logic SD_ACK_O, // DMA done pulse
    output logic SD_ERR_O, // DMA refused
    output uram_pkg::uram_word_t SB_RDATA_O // System read word
);
    import uram_pkg::*;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SRST_I);

    // Requester views: local, system CPU/DSP, DMA
    uram_addr_t req_addr [NREQ]; // Byte address
    uram_word_t req_wdata [NREQ]; // Raw write data
    uram_size_t req_size [NREQ]; // Access size
    logic [3:0] req_be [NREQ]; // Byte enables
    uram_word_t req_wlane [NREQ]; // Steered write data

    assign req_addr[REQ_LB] = LB_ADDR_I;
    assign req_addr[REQ_SC] = SC_ADDR_I;
    assign req_addr[REQ_SD] = SD_ADDR_I;
    assign req_wdata[REQ_LB] = LB_WDATA_I;
    assign req_wdata[REQ_SC] = SC_WDATA_I;
    assign req_wdata[REQ_SD] = SD_WDATA_I;
    assign req_size[REQ_LB] = LB_SIZE_I;
    assign req_size[REQ_SC] = SC_SIZE_I;
    assign req_size[REQ_SD] = SD_SIZE_I;

    // Lane steering per requester
    generate
        for (genvar g = 0; g < NREQ; g++) begin : g_lane
            uram_lane u_lane (
                .size_i(req_size[g]),
                .addr_lo_i(req_addr[g][1:0]),
                .wdata_i(req_wdata[g]),
                .be_o(req_be[g]),
                .wdata_o(req_wlane[g])
            );
        end
    endgenerate

    // Answer registers
    logic lb_ack_ff; // Local ack
    logic lb_err_ff; // Local error
    uram_word_t lb_rdata_ff; // Local read word
    logic sc_ack_ff; // CPU/DSP ack
    logic sc_err_ff; // CPU/DSP error
    logic sd_ack_ff; // DMA ack
    logic sd_err_ff; // DMA error
    uram_word_t sb_rdata_ff; // System read word

    // System port state
    uram_sst_t st_ff; // Pipeline state
    logic rr_ff; // High: DMA has the next turn
    logic s_dma_ff; // Granted master is DMA
    logic s_page_ff; // Granted page
    uram_idx_t s_idx_ff; // Granted word index
    logic s_we_ff; // Granted write
    logic [3:0] s_be_ff; // Granted enables
    uram_word_t s_wd_ff; // Granted write data

    // Local port decode, uncached window only
    logic lb_hit; // In uncached window
    uram_addr_t lb_off; // Offset into array
    logic lb_page; // Target page
    uram_idx_t lb_idx; // Word index
    assign lb_hit = uram_in_win(LB_ADDR_I, UNC_BASE, UNC_LAST);
    assign lb_off = uram_off(LB_ADDR_I, UNC_BASE);
    assign lb_page = lb_off[PAGE_BIT];
    assign lb_idx = lb_off[PAGE_BIT-1:2];

    // System port decode, cacheable window only
    logic sc_hit; // CPU/DSP in window
    logic sd_hit; // DMA in window
    uram_addr_t sc_off; // CPU/DSP offset
    uram_addr_t sd_off; // DMA offset
    assign sc_hit = uram_in_win(SC_ADDR_I, CACHE_BASE, CACHE_LAST);
    assign sd_hit = uram_in_win(SD_ADDR_I, CACHE_BASE, CACHE_LAST);
    assign sc_off = uram_off(SC_ADDR_I, CACHE_BASE);
    assign sd_off = uram_off(SD_ADDR_I, CACHE_BASE);

    // Open requests; a master is not retaken in its ack cycle
    logic sc_take; // CPU/DSP asking
    logic sd_take; // DMA asking
    logic sys_take; // Any system request
    logic pick_dma; // Arbiter picks DMA
    logic sel_hit; // Picked request decodes
    uram_addr_t sel_off; // Picked offset
    logic sys_start; // Access begins
    logic sys_refuse; // Refused at once
    assign sc_take = SC_REQ_I && !sc_ack_ff;
    assign sd_take = SD_REQ_I && !sd_ack_ff;
    assign sys_take = sc_take || sd_take;
    assign pick_dma = sd_take && (!sc_take || rr_ff);
    assign sel_hit = pick_dma ? sd_hit : sc_hit;
    assign sel_off = pick_dma ? sd_off : sc_off;
    assign sys_start = (st_ff == ST_IDLE) && sys_take && sel_hit && !SLEEP_I;
    assign sys_refuse = (st_ff == ST_IDLE) && sys_take && (!sel_hit || SLEEP_I);

    // Local go: stalls while the system port holds its page
    logic lb_open; // Request not yet answered
    logic lb_block; // Page held by system port
    logic lb_go; // Local access this cycle
    assign lb_open = LB_REQ_I && !lb_ack_ff;
    assign lb_block = (st_ff == ST_ACC) && (s_page_ff == lb_page);
    assign lb_go = lb_open && lb_hit && !lb_block;

    // System port pipeline: take, then access a cycle later
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            st_ff <= ST_IDLE;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (sys_start) begin
                        st_ff <= ST_ACC;
                    end
                end
                ST_ACC: st_ff <= ST_IDLE;
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // Turn flag set on every system grant or refusal: DMA next after a CPU/DSP pick
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            rr_ff <= RR_INIT;
        end else if (sys_start || sys_refuse) begin
            rr_ff <= !pick_dma;
        end
    end

    // Capture the granted request
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            s_dma_ff <= 1'b0;
            s_page_ff <= 1'b0;
            s_we_ff <= 1'b0;
        end else if (sys_start) begin
            s_dma_ff <= pick_dma;
            s_page_ff <= sel_off[PAGE_BIT];
            s_we_ff <= pick_dma ? SD_WE_I : SC_WE_I;
        end
    end

    // Granted index and data, no reset needed
    always_ff @(posedge CORE_CLK_I) begin
        if (sys_start) begin
            s_idx_ff <= sel_off[PAGE_BIT-1:2];
            s_be_ff <= pick_dma ? req_be[REQ_SD] : req_be[REQ_SC];
            s_wd_ff <= pick_dma ? req_wlane[REQ_SD] : req_wlane[REQ_SC];
        end
    end

    // Page banks; system port has first claim on its page
    uram_word_t bank_rd [2]; // Read word per page
    generate
        for (genvar g = 0; g < 2; g++) begin : g_page
            localparam logic PG = 1'(g);
            logic sys_on; // System port uses this page
            logic lb_on; // Local port uses this page
            uram_acc_if u_acc ();
            assign sys_on = (st_ff == ST_ACC) && (s_page_ff == PG);
            assign lb_on = lb_go && (lb_page == PG);
            assign u_acc.en = sys_on || lb_on;
            assign u_acc.we = sys_on ? s_we_ff : LB_WE_I;
            assign u_acc.be = sys_on ? s_be_ff : req_be[REQ_LB];
            assign u_acc.idx = sys_on ? s_idx_ff : lb_idx;
            assign u_acc.wdata = sys_on ? s_wd_ff : req_wlane[REQ_LB];
            assign bank_rd[g] = u_acc.rdata;
            uram_bank u_bank (
                .clk_i(CORE_CLK_I),
                .acc(u_acc)
            );
        end
    endgenerate

    // Local answers, one cycle after the go
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            lb_ack_ff <= 1'b0;
            lb_err_ff <= 1'b0;
            lb_rdata_ff <= RDATA_INIT;
        end else begin
            lb_ack_ff <= 1'b0;
            lb_err_ff <= 1'b0;
            if (lb_open && !lb_hit) begin
                // Outside the uncached window
                lb_ack_ff <= 1'b1;
                lb_err_ff <= 1'b1;
            end else if (lb_go) begin
                // Single-cycle service
                lb_ack_ff <= 1'b1;
                lb_rdata_ff <= bank_rd[lb_page];
            end
        end
    end

    // System answers: refusals next cycle, accesses after the access cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            sc_ack_ff <= 1'b0;
            sc_err_ff <= 1'b0;
            sd_ack_ff <= 1'b0;
            sd_err_ff <= 1'b0;
            sb_rdata_ff <= RDATA_INIT;
        end else begin
            sc_ack_ff <= 1'b0;
            sc_err_ff <= 1'b0;
            sd_ack_ff <= 1'b0;
            sd_err_ff <= 1'b0;
            if (sys_refuse) begin
                // Sleep or window miss
                sd_ack_ff <= pick_dma;
                sd_err_ff <= pick_dma;
                sc_ack_ff <= !pick_dma;
                sc_err_ff <= !pick_dma;
            end else if (st_ff == ST_ACC) begin
                // Access done this cycle
                sd_ack_ff <= s_dma_ff;
                sc_ack_ff <= !s_dma_ff;
                sb_rdata_ff <= bank_rd[s_page_ff];
            end
        end
    end

    // Outputs straight from registers
    assign LB_ACK_O = lb_ack_ff;
    assign LB_ERR_O = lb_err_ff;
    assign LB_RDATA_O = lb_rdata_ff;
    assign SC_ACK_O = sc_ack_ff;
    assign SC_ERR_O = sc_err_ff;
    assign SD_ACK_O = sd_ack_ff;
    assign SD_ERR_O = sd_err_ff;
    assign SB_RDATA_O = sb_rdata_ff;

    // Local access answers in one cycle
    property p_lb_one;
        lb_go |=> LB_ACK_O && !LB_ERR_O;
    endproperty
    a_lb_one: assert property (p_lb_one) else $error("local ack late");

    // Local miss answers with error
    property p_lb_miss;
        lb_open && !lb_hit |=> LB_ACK_O && LB_ERR_O;
    endproperty
    a_lb_miss: assert property (p_lb_miss) else $error("local miss not flagged");

    // Same page: system wins, local held off
    property p_prio;
        (st_ff == ST_ACC) && lb_open && lb_hit && (lb_page == s_page_ff) |=> !LB_ACK_O;
    endproperty
    a_prio: assert property (p_prio) else $error("local beat system");

    // Different pages proceed together
    property p_par;
        (st_ff == ST_ACC) && lb_open && lb_hit && (lb_page != s_page_ff) |=> LB_ACK_O;
    endproperty
    a_par: assert property (p_par) else $error("parallel access delayed");

    // System access takes two cycles
    property p_sb_lat;
        sys_start |=> !(SC_ACK_O || SD_ACK_O) ##1 (SC_ACK_O || SD_ACK_O) && !(SC_ERR_O || SD_ERR_O);
    endproperty
    a_sb_lat: assert property (p_sb_lat) else $error("system latency wrong");

    // Sleep refuses system masters
    property p_sleep;
        (st_ff == ST_IDLE) && sys_take && SLEEP_I |=> (st_ff == ST_IDLE) && (SC_ERR_O || SD_ERR_O);
    endproperty
    a_sleep: assert property (p_sleep) else $error("served in sleep");

    // Lone DMA in window is served on the system port
    property p_dma;
        (st_ff == ST_IDLE) && sd_take && !sc_take && sd_hit && !SLEEP_I |-> ##2 SD_ACK_O && !SD_ERR_O;
    endproperty
    a_dma: assert property (p_dma) else $error("dma not served");

    // Contention: the DMA, when it holds the turn, gets the answer
    property p_rr;
        (st_ff == ST_IDLE) && sc_take && sd_take && rr_ff |-> ##[1:2] SD_ACK_O;
    endproperty
    a_rr: assert property (p_rr) else $error("turn ignored");

    // Stalled local request served right after the system access
    property p_stall;
        ((st_ff == ST_ACC) && lb_open && lb_hit && (lb_page == s_page_ff)) ##1 LB_REQ_I |=> LB_ACK_O;
    endproperty
    a_stall: assert property (p_stall) else $error("stalled request lost");

    // Byte and halfword enables
    property p_be;
        (req_size[REQ_LB] == URAM_SZ_B |-> $onehot(req_be[REQ_LB]))
            and (req_size[REQ_SC] == URAM_SZ_H |-> req_be[REQ_SC] inside {4'h3, 4'hC});
    endproperty
    a_be: assert property (p_be) else $error("lane enables wrong");
endmodule
`default_nettype wire
